// File: verilog/rcn_params.svh
`ifndef RCN_PARAMS_SVH
`define RCN_PARAMS_SVH
// ==========================================================================
// register offsets (byte addresses)
`define RCN_OFF_CTRL 12'h000
`define RCN_OFF_STAT 12'h004
`define RCN_OFF_IRQ_STAT 12'h008
`define RCN_OFF_IRQ_MASK 12'h00C
`define RCN_OFF_TBLOCK 12'h010
`define RCN_OFF_FLO 12'h014
`define RCN_OFF_FHI 12'h018
`define RCN_OFF_VLO 12'h01C
`define RCN_OFF_VHI 12'h020
`define RCN_OFF_TRIG_EN 12'h024
// ==========================================================================
// ctrl field positions
`define RCN_CTRL_EN_BIT 0
`define RCN_CTRL_SEL_LSB 1
`define RCN_CTRL_EXT_EN_BIT 3
`define RCN_CTRL_AVG_BIT 4
// ==========================================================================
// reset values: frequency in mHz, voltage in 0.1 % of nominal
`define RCN_RST_CTRL 32'h0000_0001
`define RCN_RST_TBLOCK_S 32'h0000_0258
`define RCN_RST_FLO 32'h0000_B98C
`define RCN_RST_FHI 32'h0000_C92C
`define RCN_RST_VLO 32'h0000_03B6
`define RCN_RST_VHI 32'h0000_04F6
`define RCN_RST_TRIG_EN 32'h0000_003F
// ==========================================================================
// timing
`define RCN_CLK_HZ 100000000
`define RCN_TICK_HZ 1
`define RCN_TICK_DIV (`RCN_CLK_HZ / `RCN_TICK_HZ)
`endif

// File: verilog/rcn_pkg.sv
package rcn_pkg;
  typedef enum logic [1:0] {
    RCN_SEL_INT = 2'h0,
    RCN_SEL_EXT = 2'h1,
    RCN_SEL_BOTH = 2'h2
  } rcn_sel_t;
  typedef enum logic [1:0] {
    RCN_IDLE,
    RCN_BLOCK,
    RCN_RELEASE
  } rcn_state_t;
endpackage : rcn_pkg

// File: verilog/rcn_tick_if.sv
`timescale 1ns/1ps
interface rcn_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : rcn_tick_if

// File: verilog/rcn_tick_div.sv
`timescale 1ns/1ps
`include "rcn_params.svh"
module rcn_tick_div #(
  parameter int unsigned DIV = `RCN_TICK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  rcn_tick_if.src t
);
  logic [31:0] cnt_ff;
  logic tick_ff;
  wire logic at_end = (cnt_ff == 32'(DIV - 1));
  // ========================================================================
  // processing tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0000_0000;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= at_end ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
      tick_ff <= at_end;
    end
  end
  assign t.tick = tick_ff;
endmodule : rcn_tick_div

// File: verilog/rcn_sync.sv
`timescale 1ns/1ps
module rcn_sync #(
  parameter int unsigned W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  // ========================================================================
  // two-stage synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end
  assign q = s2_ff;
endmodule : rcn_sync

// File: verilog/rcn_reconnect.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "rcn_params.svh"
module rcn_reconnect #(
  parameter int unsigned NTRIG = 6,
  parameter int unsigned TICK_DIV = `RCN_TICK_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NTRIG-1:0] decouple_trip,
  input wire logic aux_trigger,
  input wire logic external_coupling_release,
  input wire logic [15:0] vll_ab,
  input wire logic [15:0] vll_bc,
  input wire logic [15:0] vll_ca,
  input wire logic [15:0] vavg_ab,
  input wire logic [15:0] vavg_bc,
  input wire logic [15:0] vavg_ca,
  input wire logic [15:0] freq_mhz,
  output logic gen_release,
  output logic irq
);
  // ========================================================================
  // pin inputs synchronised
  logic [NTRIG-1:0] trip_s;
  logic aux_s;
  logic ext_s;
  rcn_sync #(.W(NTRIG)) u_sync_trip (
    .pclk(pclk), .presetn(presetn), .d(decouple_trip), .q(trip_s));
  rcn_sync #(.W(2)) u_sync_misc (
    .pclk(pclk), .presetn(presetn),
    .d({aux_trigger, external_coupling_release}), .q({aux_s, ext_s}));

  rcn_tick_if tk ();
  rcn_tick_div #(.DIV(TICK_DIV)) u_tick (
    .pclk(pclk), .presetn(presetn), .t(tk));

  // ========================================================================
  // registers
  logic [31:0] ctrl_ff;
  logic [31:0] tblock_ff;
  logic [15:0] flo_ff;
  logic [15:0] fhi_ff;
  logic [15:0] vlo_ff;
  logic [15:0] vhi_ff;
  logic [NTRIG-1:0] trig_en_ff;
  logic [2:0] ist_ff;
  logic [2:0] imask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic rel_ff;
  logic [31:0] cnt_ff;
  logic trig_d_ff;
  logic band_d_ff;
  rcn_pkg::rcn_state_t st_ff;
  rcn_pkg::rcn_state_t nxt_st;

  // ========================================================================
  // apb decode
  wire logic setup = psel && !penable;
  wire logic acc = psel && penable;
  wire logic wr = acc && pready_ff && pwrite;
  wire logic rd = setup && !pwrite;
  wire logic hit_ctrl = (paddr == `RCN_OFF_CTRL);
  wire logic hit_stat = (paddr == `RCN_OFF_STAT);
  wire logic hit_ist = (paddr == `RCN_OFF_IRQ_STAT);
  wire logic hit_imask = (paddr == `RCN_OFF_IRQ_MASK);
  wire logic hit_tb = (paddr == `RCN_OFF_TBLOCK);
  wire logic hit_flo = (paddr == `RCN_OFF_FLO);
  wire logic hit_fhi = (paddr == `RCN_OFF_FHI);
  wire logic hit_vlo = (paddr == `RCN_OFF_VLO);
  wire logic hit_vhi = (paddr == `RCN_OFF_VHI);
  wire logic hit_ten = (paddr == `RCN_OFF_TRIG_EN);
  wire logic hit_any = hit_ctrl | hit_stat | hit_ist | hit_imask | hit_tb
    | hit_flo | hit_fhi | hit_vlo | hit_vhi | hit_ten;

  // ========================================================================
  // configuration fields
  wire logic en = ctrl_ff[`RCN_CTRL_EN_BIT];
  wire logic [1:0] sel = ctrl_ff[`RCN_CTRL_SEL_LSB +: 2];
  wire logic ext_en = ctrl_ff[`RCN_CTRL_EXT_EN_BIT];
  wire logic use_avg = ctrl_ff[`RCN_CTRL_AVG_BIT];

  // ========================================================================
  // mains checks
  wire logic [15:0] v_ab = use_avg ? vavg_ab : vll_ab;
  wire logic [15:0] v_bc = use_avg ? vavg_bc : vll_bc;
  wire logic [15:0] v_ca = use_avg ? vavg_ca : vll_ca;
  function automatic logic in_win(input logic [15:0] v,
      input logic [15:0] lo, input logic [15:0] hi);
    in_win = (v > lo) && (v <= hi);
  endfunction : in_win
  // line-to-line voltages, one shared window for both sets
  wire logic v_ok = in_win(v_ab, vlo_ff, vhi_ff)
    && in_win(v_bc, vlo_ff, vhi_ff) && in_win(v_ca, vlo_ff, vhi_ff);
  // frequency window inclusive
  wire logic f_ok = (freq_mhz >= flo_ff) && (freq_mhz <= fhi_ff);
  wire logic ext_ok = ext_en && ext_s;
  logic volt_cond;
  always_comb begin
    unique case (sel)
      2'h0: volt_cond = v_ok;
      2'h1: volt_cond = ext_ok;
      2'h2: volt_cond = v_ok && ext_ok;
      default: volt_cond = 1'b0;
    endcase
  end
  // frequency judged except in external-only, which trusts the remote signal
  wire logic band_ok = volt_cond && (f_ok || sel == 2'h1);
  wire logic trig = en && (|(trip_s & trig_en_ff) || aux_s);
  wire logic expired = (cnt_ff >= tblock_ff);
  wire logic trig_rise = trig && !trig_d_ff;
  wire logic band_fall = !band_ok && band_d_ff;

  // ========================================================================
  // state machine; coupling breaker trip needs no extra logic
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      rcn_pkg::RCN_IDLE:
        if (trig) nxt_st = rcn_pkg::RCN_BLOCK;
      rcn_pkg::RCN_BLOCK:
        if (!trig && expired && band_ok) nxt_st = rcn_pkg::RCN_RELEASE;
      rcn_pkg::RCN_RELEASE:
        if (trig || !band_ok || !en) nxt_st = rcn_pkg::RCN_BLOCK;
    endcase
    if (!en) nxt_st = rcn_pkg::RCN_IDLE;
  end
  wire logic restart = trig || !band_ok;
  wire logic [31:0] nxt_cnt = restart ? 32'h0000_0000 :
    (tk.tick && !expired) ? cnt_ff + 32'h0000_0001 : cnt_ff;
  wire logic nxt_rel = (nxt_st == rcn_pkg::RCN_RELEASE) && !trig;

  wire logic [2:0] ev = {band_fall, nxt_rel && !rel_ff, trig_rise};
  wire logic [2:0] nxt_ist = ev | (ist_ff & ~((rd && hit_ist) ? 3'h7 : 3'h0));
  wire logic [31:0] stat_val = {28'h000_0000, band_ok, expired,
    st_ff == rcn_pkg::RCN_BLOCK, rel_ff};
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) nxt_rdata = ctrl_ff;
    if (hit_stat) nxt_rdata = stat_val;
    if (hit_ist) nxt_rdata = {29'h0, ist_ff};
    if (hit_imask) nxt_rdata = {29'h0, imask_ff};
    if (hit_tb) nxt_rdata = tblock_ff;
    if (hit_flo) nxt_rdata = {16'h0000, flo_ff};
    if (hit_fhi) nxt_rdata = {16'h0000, fhi_ff};
    if (hit_vlo) nxt_rdata = {16'h0000, vlo_ff};
    if (hit_vhi) nxt_rdata = {16'h0000, vhi_ff};
    if (hit_ten) nxt_rdata = {{(32-NTRIG){1'b0}}, trig_en_ff};
  end

  // ========================================================================
  // apb registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `RCN_RST_CTRL;
      tblock_ff <= `RCN_RST_TBLOCK_S;
      flo_ff <= 16'(`RCN_RST_FLO);
      fhi_ff <= 16'(`RCN_RST_FHI);
      vlo_ff <= 16'(`RCN_RST_VLO);
      vhi_ff <= 16'(`RCN_RST_VHI);
      trig_en_ff <= NTRIG'(`RCN_RST_TRIG_EN);
      imask_ff <= 3'h0;
    end else if (wr) begin
      if (hit_ctrl) ctrl_ff <= {27'h0, pwdata[4:0]};
      if (hit_tb) tblock_ff <= pwdata;
      if (hit_flo) flo_ff <= pwdata[15:0];
      if (hit_fhi) fhi_ff <= pwdata[15:0];
      if (hit_vlo) vlo_ff <= pwdata[15:0];
      if (hit_vhi) vhi_ff <= pwdata[15:0];
      if (hit_ten) trig_en_ff <= pwdata[NTRIG-1:0];
      if (hit_imask) imask_ff <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !hit_any;
      if (rd) prdata_ff <= nxt_rdata;
    end
  end

  // ========================================================================
  // core state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= rcn_pkg::RCN_IDLE;
      cnt_ff <= 32'h0000_0000;
      rel_ff <= 1'b0;
      trig_d_ff <= 1'b0;
      band_d_ff <= 1'b0;
      ist_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      rel_ff <= nxt_rel;
      trig_d_ff <= trig;
      band_d_ff <= band_ok;
      ist_ff <= nxt_ist;
      irq_ff <= |(nxt_ist & ~imask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign gen_release = rel_ff;
  assign irq = irq_ff;

  // ========================================================================
  // assertions
  property p_trig_kill;
    @(posedge pclk) disable iff (!presetn)
    trig |=> !gen_release;
  endproperty
  a_trig_kill: assert property (p_trig_kill)
    else $error("release seen after trigger");

  property p_rel_expired;
    @(posedge pclk) disable iff (!presetn)
    $rose(gen_release) |-> $past(expired);
  endproperty
  a_rel_expired: assert property (p_rel_expired)
    else $error("release before block timer expiry");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (!band_ok && en) |=> (cnt_ff == 32'h0000_0000);
  endproperty
  a_restart: assert property (p_restart)
    else $error("timer not restarted on band loss");

  property p_trig_start;
    @(posedge pclk) disable iff (!presetn)
    trig |=> (st_ff == rcn_pkg::RCN_BLOCK) && (cnt_ff == 32'h0000_0000);
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger did not start block timer");

  property p_rel_band;
    @(posedge pclk) disable iff (!presetn)
    $rose(gen_release) |-> $past(band_ok);
  endproperty
  a_rel_band: assert property (p_rel_band)
    else $error("release without healthy mains");

  property p_both_and;
    @(posedge pclk) disable iff (!presetn)
    (sel == 2'h2 && !(v_ok && ext_ok)) |=> !gen_release;
  endproperty
  a_both_and: assert property (p_both_and)
    else $error("combined mode released without both");

  property p_tick_only;
    @(posedge pclk) disable iff (!presetn)
    (cnt_ff != $past(cnt_ff) && cnt_ff != 32'h0000_0000)
      |-> $past(tk.tick);
  endproperty
  a_tick_only: assert property (p_tick_only)
    else $error("timer advanced without tick");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(|(nxt_ist & ~imask_ff));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt level mismatch");

  property p_idle_off;
    @(posedge pclk) disable iff (!presetn)
    !en |=> (st_ff == rcn_pkg::RCN_IDLE) && !gen_release;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("disabled block left idle or released");

  property p_ext_only;
    @(posedge pclk) disable iff (!presetn)
    (sel == 2'h1 && !ext_ok) |=> !gen_release;
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("external mode released without remote signal");

  property p_int_only;
    @(posedge pclk) disable iff (!presetn)
    (sel == 2'h0 && !v_ok) |=> !gen_release;
  endproperty
  a_int_only: assert property (p_int_only)
    else $error("internal mode released with bad voltage");

  property p_freq;
    @(posedge pclk) disable iff (!presetn)
    (sel != 2'h1 && !f_ok) |=> !gen_release;
  endproperty
  a_freq: assert property (p_freq)
    else $error("released with frequency out of window");

  property p_cnt_hold;
    @(posedge pclk) disable iff (!presetn)
    (expired && !restart) |=> (cnt_ff == $past(cnt_ff));
  endproperty
  a_cnt_hold: assert property (p_cnt_hold)
    else $error("timer moved after expiry");

  property p_ist_set;
    @(posedge pclk) disable iff (!presetn)
    trig_rise |=> ist_ff[0];
  endproperty
  a_ist_set: assert property (p_ist_set)
    else $error("trigger status bit not set");

  property p_rel_level;
    @(posedge pclk) disable iff (!presetn)
    gen_release |-> (st_ff == rcn_pkg::RCN_RELEASE);
  endproperty
  a_rel_level: assert property (p_rel_level)
    else $error("release outside release state");
endmodule : rcn_reconnect

// File: tb/rcn_grid_model.sv
`timescale 1ns/1ps
// ==========================================================================
// mains and decoupling source model
module rcn_grid_model (
  input wire logic pclk,
  input wire logic [5:0] trip_req,
  input wire logic aux_req,
  input wire logic ext_req,
  input wire logic [15:0] v_req,
  input wire logic [15:0] va_req,
  input wire logic [15:0] f_req,
  output logic [5:0] trip,
  output logic aux,
  output logic ext,
  output logic [15:0] vll,
  output logic [15:0] vavg,
  output logic [15:0] freq
);
  always_ff @(posedge pclk) begin
    trip <= trip_req;
    aux <= aux_req;
    ext <= ext_req;
    vll <= v_req;
    vavg <= va_req;
    freq <= f_req;
  end
endmodule : rcn_grid_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int DIV = 10;
  localparam int T = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serr, gen_release, irq;
  logic [5:0] trip_req = 6'h00;
  logic aux_req = 1'b0;
  logic ext_req = 1'b0;
  logic [15:0] v_req = 16'h03E8;
  logic [15:0] va_req = 16'h03E8;
  logic [15:0] f_req = 16'hC350;
  logic [5:0] trip;
  logic aux, ext, ex, vg, ag, avg, fg, exp_r;
  logic [15:0] vll, vavg, freq;
  logic [11:0] ra [6];
  logic [31:0] rv [6];
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  always #5 pclk = ~pclk;
  rcn_grid_model i_grid (.pclk(pclk), .trip_req(trip_req), .aux_req(aux_req),
    .ext_req(ext_req), .v_req(v_req), .va_req(va_req), .f_req(f_req),
    .trip(trip), .aux(aux), .ext(ext), .vll(vll), .vavg(vavg), .freq(freq));
  rcn_reconnect #(.NTRIG(6), .TICK_DIV(DIV)) i_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .decouple_trip(trip), .aux_trigger(aux),
    .external_coupling_release(ext), .vll_ab(vll), .vll_bc(vll),
    .vll_ca(vll), .vavg_ab(vavg), .vavg_bc(vavg), .vavg_ca(vavg),
    .freq_mhz(freq), .gen_release(gen_release), .irq(irq));
  // ==========================================================================
  // checks and verdict
  task check_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  task check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word
  task give_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  // ==========================================================================
  // apb master
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic exp_rel(input logic [1:0] s, input logic e,
    input logic b);
    if (s == 2'h1) return e;
    if (s == 2'h2) return e & b;
    return b;
  endfunction : exp_rel
  task trip_pulse(input logic [5:0] m);
    trip_req <= m;
    repeat (3) @(posedge pclk);
    trip_req <= 6'h00;
  endtask : trip_pulse
  // ==========================================================================
  // main sequence
  initial begin
    ra = '{12'h000, 12'h010, 12'h014, 12'h018, 12'h01C, 12'h024};
    rv = '{32'h0000_0001, 32'h0000_0258, 32'h0000_B98C, 32'h0000_C92C,
      32'h0000_03B6, 32'h0000_003F};
    rd = $urandom(64);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      check_word("reset value", rv[i], rd);
    end
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    check_bit("unmapped error", 1'b1, serr);
    apb(1'b1, 12'h010, T);
    apb(1'b1, 12'h018, 32'h0000_C382);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      {ex, vg, ag, avg, fg} = 5'($urandom);
      apb(1'b1, 12'h000, {27'h0, avg, i % 3 != 0, 2'(i % 3), 1'b1});
      ext_req <= ex;
      v_req <= vg ? 16'h03B7 : 16'h03B6;
      va_req <= ag ? 16'h03B7 : 16'h03B6;
      f_req <= fg ? 16'hC350 : 16'hC3B4;
      trip_pulse(6'h01 << ($urandom % 6));
      repeat ((T - 1) * DIV) @(posedge pclk);
      check_bit("early release", 1'b0, gen_release);
      repeat (DIV + 20) @(posedge pclk);
      exp_r = exp_rel(2'(i % 3), ex, (avg ? ag : vg) & fg);
      check_bit("release", exp_r, gen_release);
    end
    apb(1'b1, 12'h000, 32'h0000_0001);
    v_req <= 16'h03E8;
    f_req <= 16'hC350;
    apb(1'b0, 12'h008, 32'h0000_0000);
    apb(1'b1, 12'h00C, 32'h0000_0007);
    trip_pulse(6'h20);
    repeat (6) @(posedge pclk);
    check_bit("masked irq", 1'b0, irq);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check_bit("irq", 1'b1, irq);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check_bit("trigger status", 1'b1, rd[0]);
    repeat (2) @(posedge pclk);
    check_bit("cleared irq", 1'b0, irq);
    n = 0;
    while (gen_release !== 1'b1 && n < T * DIV + 30) begin
      @(posedge pclk);
      n++;
    end
    check_bit("release up", 1'b1, gen_release);
    aux_req <= 1'b1;
    repeat (5) @(posedge pclk);
    check_bit("release drop", 1'b0, gen_release);
    aux_req <= 1'b0;
    repeat (3 * DIV) @(posedge pclk);
    f_req <= 16'hB000;
    repeat (3) @(posedge pclk);
    f_req <= 16'hC350;
    repeat (DIV + 7) @(posedge pclk);
    check_bit("restarted block", 1'b0, gen_release);
    repeat (3 * DIV) @(posedge pclk);
    check_bit("release again", 1'b1, gen_release);
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    check_bit("disabled release", 1'b0, gen_release);
    give_verdict();
  end
endmodule : testbench
